// ===== verilog/range_type_map.svh
`ifndef RANGE_TYPE_MAP_SVH
`define RANGE_TYPE_MAP_SVH

// ==========================================================
// Register indices seen by the configuration port.
`define RT_IDX_W 8
`define RT_IDX_DEFAULT 8'h00
`define RT_IDX_FIXED_FIRST 8'h01
`define RT_IDX_FIXED_LAST 8'h0B
`define RT_IDX_VAR_FIRST 8'h10
`define RT_IDX_VAR_LAST 8'h1F

// ==========================================================
// Counts and field positions.
`define RT_FIXED_REGS 11
`define RT_VAR_PAIRS 8
`define RT_ADDR_W 36
`define RT_TYPE_LO 0
`define RT_TYPE_HI 7
`define RT_FE_BIT 10
`define RT_EN_BIT 11
`define RT_VALID_BIT 11
`define RT_FIELD_LO 12
`define RT_FIELD_HI 35
`define RT_FIELD_W 24

// ==========================================================
// Reserved bit masks of the writable registers.
`define RT_DEFAULT_RSVD 64'hFFFF_FFFF_FFFF_F300
`define RT_BASE_RSVD 64'hFFFF_FFF0_0000_0F00
`define RT_MASK_RSVD 64'hFFFF_FFF0_0000_07FF

// ==========================================================
// Reset values.
`define RT_EN_RST 1'b0
`define RT_VALID_RST 1'b0
`define RT_DATA_RST 64'h0000_0000_0000_0000

`endif

// ===== verilog/range_type_pkg.sv
`default_nettype none
`include "range_type_map.svh"

package range_type_pkg;

    // ======================================================
    // Memory type encodings.
    typedef enum logic [7:0] {
        uncached_type = 8'h00,
        write_combining_type = 8'h01,
        write_through_type = 8'h04,
        write_protected_type = 8'h05,
        write_back_type = 8'h06
    } mem_type_t;

    // ======================================================
    // One variable pair.
    typedef struct packed {
        logic [`RT_FIELD_W-1:0] base;
        logic [7:0] rtype;
        logic [`RT_FIELD_W-1:0] mask;
        logic valid;
    } var_pair_t;

    // ======================================================
    // Whole register state of the unit.
    typedef struct packed {
        logic [7:0] def_type;
        logic fixed_ranges_on;
        logic enable;
        logic [`RT_FIXED_REGS-1:0][63:0] fixed;
        var_pair_t [`RT_VAR_PAIRS-1:0] pairs;
        logic [63:0] rdata;
        logic rd_valid;
        logic fault;
    } state_t;

endpackage

`default_nettype wire

// ===== verilog/var_range_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "range_type_map.svh"

interface var_range_if;
    logic [`RT_FIELD_W-1:0] base;
    logic [`RT_FIELD_W-1:0] mask;
    logic valid;
    logic [`RT_ADDR_W-1:0] addr;
    logic hit;

    modport owner (output base, output mask, output valid, output addr, input hit);
    modport matcher (input base, input mask, input valid, input addr, output hit);
endinterface

`default_nettype wire

// ===== verilog/var_range_match.sv
`timescale 1ns/100ps
`default_nettype none
`include "range_type_map.svh"

module var_range_match (
    var_range_if.matcher m
);
    import range_type_pkg::*;

    // ======================================================
    // Page number of the address against base, both under the mask.
    assign m.hit = m.valid &&
        ((m.addr[`RT_FIELD_HI:`RT_FIELD_LO] & m.mask) == (m.base & m.mask));
endmodule

`default_nettype wire

// ===== verilog/range_type_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "range_type_map.svh"

// Overview of operation
// - Unmatched address returns the default type.
// - Default type accepts 0,1,4,5,6 only.
// - Fixed enable; fixed beats variable ranges.
// - Fixed off: variable pairs cover low region.
// - Global enable off: everything uncached.
// - Default register reserved bits fault if nonzero.
// - Eleven fixed registers, eight type bytes each.
// - First fixed register: eight 64K sub-ranges.
// - Two registers: sixteen 16K sub-ranges.
// - Eight registers: sixty-four 4K sub-ranges.
// - Lowest sub-range in lowest byte.
// - Eight base/mask pairs, numbered 0 to 7.
// - Base holds type and 24-bit aligned base.
// - Match when masked address equals masked base.
// - Valid flag enables a pair.
// - Reserved base/mask bit writes fault.
// - Uncached overlap with uncached/write-back gives uncached.
// - Mask gaps fall to the default type.
// - Access only through config register port.
// - Only the five encodings are legal.
// - Write-through with write-back gives write-through.
// - Reset clears valid flags and global enable.

module range_type_unit (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Configuration register port.
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [`RT_IDX_W-1:0] cfg_index,
    input wire logic [63:0] cfg_wdata,
    output logic [63:0] cfg_rdata,
    output logic cfg_rd_valid,
    output logic protection_fault,
    // Address lookup.
    input wire logic [`RT_ADDR_W-1:0] lookup_addr,
    output range_type_pkg::mem_type_t lookup_type
);
    import range_type_pkg::*;

    state_t s_r;
    state_t s_nxt;

    // ======================================================
    // Encoding check.
    function automatic logic legal_type(input logic [7:0] t);
        legal_type = (t == uncached_type) || (t == write_combining_type) ||
                     (t == write_through_type) || (t == write_protected_type) ||
                     (t == write_back_type);
    endfunction

    function automatic logic legal_fixed(input logic [63:0] d);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ok = ok && legal_type(d[8*i +: 8]);
        end
        legal_fixed = ok;
    endfunction

    // ======================================================
    // Register decode. A faulting write changes nothing, so software
    // never sees a half applied value.
    logic idx_fixed;
    logic idx_var;
    logic [3:0] fixed_sel;
    logic [2:0] pair_sel;
    logic pair_is_mask;

    assign idx_fixed = (cfg_index >= `RT_IDX_FIXED_FIRST) && (cfg_index <= `RT_IDX_FIXED_LAST);
    assign idx_var = (cfg_index >= `RT_IDX_VAR_FIRST) && (cfg_index <= `RT_IDX_VAR_LAST);
    assign fixed_sel = 4'(cfg_index - `RT_IDX_FIXED_FIRST);
    assign pair_sel = cfg_index[3:1];
    assign pair_is_mask = cfg_index[0];

    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_valid = 1'b0;
        s_nxt.fault = 1'b0;
        if (cfg_wr) begin
            if (cfg_index == `RT_IDX_DEFAULT) begin
                if (!legal_type(cfg_wdata[`RT_TYPE_HI:`RT_TYPE_LO]) ||
                    ((cfg_wdata & `RT_DEFAULT_RSVD) != 64'h0)) begin
                    s_nxt.fault = 1'b1;
                end else begin
                    s_nxt.def_type = cfg_wdata[`RT_TYPE_HI:`RT_TYPE_LO];
                    s_nxt.fixed_ranges_on = cfg_wdata[`RT_FE_BIT];
                    s_nxt.enable = cfg_wdata[`RT_EN_BIT];
                end
            end else if (idx_fixed) begin
                if (!legal_fixed(cfg_wdata)) begin
                    s_nxt.fault = 1'b1;
                end else begin
                    s_nxt.fixed[fixed_sel] = cfg_wdata;
                end
            end else if (idx_var && !pair_is_mask) begin
                if (!legal_type(cfg_wdata[`RT_TYPE_HI:`RT_TYPE_LO]) ||
                    ((cfg_wdata & `RT_BASE_RSVD) != 64'h0)) begin
                    s_nxt.fault = 1'b1;
                end else begin
                    s_nxt.pairs[pair_sel].base = cfg_wdata[`RT_FIELD_HI:`RT_FIELD_LO];
                    s_nxt.pairs[pair_sel].rtype = cfg_wdata[`RT_TYPE_HI:`RT_TYPE_LO];
                end
            end else if (idx_var) begin
                if ((cfg_wdata & `RT_MASK_RSVD) != 64'h0) begin
                    s_nxt.fault = 1'b1;
                end else begin
                    s_nxt.pairs[pair_sel].mask = cfg_wdata[`RT_FIELD_HI:`RT_FIELD_LO];
                    s_nxt.pairs[pair_sel].valid = cfg_wdata[`RT_VALID_BIT];
                end
            end else begin
                s_nxt.fault = 1'b1;
            end
        end else if (cfg_rd) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rdata = `RT_DATA_RST;
            if (cfg_index == `RT_IDX_DEFAULT) begin
                s_nxt.rdata[`RT_TYPE_HI:`RT_TYPE_LO] = s_r.def_type;
                s_nxt.rdata[`RT_FE_BIT] = s_r.fixed_ranges_on;
                s_nxt.rdata[`RT_EN_BIT] = s_r.enable;
            end else if (idx_fixed) begin
                s_nxt.rdata = s_r.fixed[fixed_sel];
            end else if (idx_var && !pair_is_mask) begin
                s_nxt.rdata[`RT_FIELD_HI:`RT_FIELD_LO] = s_r.pairs[pair_sel].base;
                s_nxt.rdata[`RT_TYPE_HI:`RT_TYPE_LO] = s_r.pairs[pair_sel].rtype;
            end else if (idx_var) begin
                s_nxt.rdata[`RT_FIELD_HI:`RT_FIELD_LO] = s_r.pairs[pair_sel].mask;
                s_nxt.rdata[`RT_VALID_BIT] = s_r.pairs[pair_sel].valid;
            end else begin
                s_nxt.rd_valid = 1'b0;
                s_nxt.fault = 1'b1;
            end
        end
    end

    // Only the enable and the valid flags need a reset; the rest is
    // cleared too so simulation never carries unknowns into the lookup.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.enable <= `RT_EN_RST;
            for (int p = 0; p < `RT_VAR_PAIRS; p++) begin
                s_r.pairs[p].valid <= `RT_VALID_RST;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cfg_rdata = s_r.rdata;
    assign cfg_rd_valid = s_r.rd_valid;
    assign protection_fault = s_r.fault;

    // ======================================================
    // Variable pair matchers.
    logic [`RT_VAR_PAIRS-1:0] var_hit;
    logic [`RT_VAR_PAIRS-1:0] pair_valid;

    for (genvar g = 0; g < `RT_VAR_PAIRS; g++) begin : g_pair
        var_range_if vif ();
        assign vif.base = s_r.pairs[g].base;
        assign vif.mask = s_r.pairs[g].mask;
        assign vif.valid = s_r.pairs[g].valid;
        assign vif.addr = lookup_addr;
        assign var_hit[g] = vif.hit;
        assign pair_valid[g] = s_r.pairs[g].valid;
        var_range_match u_match (
            .m(vif)
        );
    end

    // ======================================================
    // Fixed range select within the first megabyte.
    logic low_meg;
    logic [3:0] fix_reg;
    logic [2:0] fix_byte;
    logic [7:0] fix_type;

    assign low_meg = (lookup_addr[`RT_ADDR_W-1:20] == 16'h0);

    always_comb begin
        if (!lookup_addr[19]) begin
            fix_reg = 4'h0;
            fix_byte = lookup_addr[18:16];
        end else if (!lookup_addr[18]) begin
            fix_reg = {3'h0, lookup_addr[17]} + 4'h1;
            fix_byte = lookup_addr[16:14];
        end else begin
            fix_reg = {1'b0, lookup_addr[17:15]} + 4'h3;
            fix_byte = lookup_addr[14:12];
        end
        fix_type = s_r.fixed[fix_reg][8*fix_byte +: 8];
    end

    // ======================================================
    // Combine variable hits. Overlaps other than the two documented
    // pairings are undefined; there any uncached hit still wins, then
    // write-through with write-back, and otherwise the lowest pair hit wins.
    logic any_hit;
    logic any_uc;
    logic any_wt;
    logic any_wb;
    logic [7:0] first_type;
    logic use_fixed;

    always_comb begin
        any_hit = 1'b0;
        any_uc = 1'b0;
        any_wt = 1'b0;
        any_wb = 1'b0;
        first_type = uncached_type;
        for (int p = `RT_VAR_PAIRS - 1; p >= 0; p--) begin
            if (var_hit[p]) begin
                any_hit = 1'b1;
                first_type = s_r.pairs[p].rtype;
                any_uc = any_uc || (s_r.pairs[p].rtype == uncached_type);
                any_wt = any_wt || (s_r.pairs[p].rtype == write_through_type);
                any_wb = any_wb || (s_r.pairs[p].rtype == write_back_type);
            end
        end
    end

    assign use_fixed = s_r.fixed_ranges_on && low_meg;

    always_comb begin
        if (!s_r.enable) begin
            lookup_type = uncached_type;
        end else if (use_fixed) begin
            lookup_type = mem_type_t'(fix_type);
        end else if (any_uc) begin
            lookup_type = uncached_type;
        end else if (any_wt && any_wb) begin
            lookup_type = write_through_type;
        end else if (any_hit) begin
            lookup_type = mem_type_t'(first_type);
        end else begin
            lookup_type = mem_type_t'(s_r.def_type);
        end
    end

    // ======================================================
    // Checks.
    a_disabled_uncached: assert property (@(posedge clk) disable iff (!resetn)
        !s_r.enable |-> lookup_type == uncached_type)
        else $error("Disabled unit returned a cached type.");

    a_default_fallback: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && !use_fixed && (var_hit == '0) |-> lookup_type == s_r.def_type)
        else $error("Unmatched address did not return the default type.");

    a_fixed_priority: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && s_r.fixed_ranges_on && low_meg |-> lookup_type == fix_type)
        else $error("Fixed range type did not take priority.");

    a_uncached_overlap: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && !use_fixed && any_uc |-> lookup_type == uncached_type)
        else $error("Uncached overlap did not resolve to uncached.");

    a_wt_over_wb: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && !use_fixed && !any_uc && any_wt && any_wb
        |-> lookup_type == write_through_type)
        else $error("Write-through with write-back did not give write-through.");

    a_invalid_nohit: assert property (@(posedge clk) disable iff (!resetn)
        !s_r.pairs[0].valid |-> !var_hit[0])
        else $error("Disabled pair reported a match.");

    a_bad_default: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && cfg_index == `RT_IDX_DEFAULT && !legal_type(cfg_wdata[7:0])
        |=> protection_fault && s_r.def_type == $past(s_r.def_type))
        else $error("Illegal default type was accepted.");

    a_default_rsvd: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && cfg_index == `RT_IDX_DEFAULT && ((cfg_wdata & `RT_DEFAULT_RSVD) != 64'h0)
        |=> protection_fault ##1 (!protection_fault || $past(cfg_wr || cfg_rd)))
        else $error("Reserved default bits written without a fault.");

    a_var_rsvd: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && idx_var && pair_is_mask && ((cfg_wdata & `RT_MASK_RSVD) != 64'h0)
        |=> protection_fault && s_r.pairs == $past(s_r.pairs))
        else $error("Reserved mask bits written without a fault.");

    a_read_answer: assert property (@(posedge clk) disable iff (!resetn)
        cfg_rd && !cfg_wr && cfg_index == `RT_IDX_DEFAULT
        |=> cfg_rd_valid && cfg_rdata[`RT_EN_BIT] == $past(s_r.enable))
        else $error("Default register read did not answer next cycle.");

    a_default_write: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && cfg_index == `RT_IDX_DEFAULT && legal_type(cfg_wdata[`RT_TYPE_HI:`RT_TYPE_LO])
        && ((cfg_wdata & `RT_DEFAULT_RSVD) == 64'h0)
        |=> !protection_fault && s_r.def_type == $past(cfg_wdata[`RT_TYPE_HI:`RT_TYPE_LO])
        && s_r.fixed_ranges_on == $past(cfg_wdata[`RT_FE_BIT])
        && s_r.enable == $past(cfg_wdata[`RT_EN_BIT]))
        else $error("Legal default write was not applied.");

    a_fault_cause: assert property (@(posedge clk) disable iff (!resetn)
        protection_fault |-> $past(cfg_wr || cfg_rd))
        else $error("Fault raised without an access.");

    a_fault_pulse: assert property (@(posedge clk) disable iff (!resetn)
        protection_fault && !cfg_wr && !cfg_rd |=> !protection_fault)
        else $error("Fault stood longer than one cycle.");

    a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!resetn)
        cfg_rd_valid |-> $past(cfg_rd && !cfg_wr))
        else $error("Read answer without a read request.");

    a_unmapped_fault: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_wr || cfg_rd) && !idx_fixed && !idx_var && cfg_index != `RT_IDX_DEFAULT
        |=> protection_fault && !cfg_rd_valid)
        else $error("Unmapped index access did not fault.");

    a_fixed_bad: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && idx_fixed && !legal_fixed(cfg_wdata)
        |=> protection_fault && s_r.fixed == $past(s_r.fixed))
        else $error("Illegal fixed range type was accepted.");

    a_fixed_write: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && idx_fixed && legal_fixed(cfg_wdata) |=> !protection_fault)
        else $error("Legal fixed range write faulted.");

    a_read_fixed: assert property (@(posedge clk) disable iff (!resetn)
        cfg_rd && !cfg_wr && idx_fixed
        |=> cfg_rd_valid && cfg_rdata == $past(s_r.fixed[fixed_sel]))
        else $error("Fixed range read returned the wrong word.");

    a_base_bad: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && idx_var && !pair_is_mask && ((cfg_wdata & `RT_BASE_RSVD) != 64'h0)
        |=> protection_fault && s_r.pairs == $past(s_r.pairs))
        else $error("Reserved base bits written without a fault.");

    a_invalid_all: assert property (@(posedge clk) disable iff (!resetn)
        (var_hit & ~pair_valid) == '0)
        else $error("A pair without its valid flag reported a match.");

    a_variable_low: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && !s_r.fixed_ranges_on && low_meg && var_hit == 8'h08
        |-> lookup_type == s_r.pairs[3].rtype)
        else $error("Variable pair was not applied below one megabyte.");

    a_fixed_first: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && s_r.fixed_ranges_on && lookup_addr[`RT_ADDR_W-1:16] == 20'h0
        |-> lookup_type == s_r.fixed[0][7:0])
        else $error("Lowest 64K sub-range did not use its byte.");

    a_fixed_mid: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && s_r.fixed_ranges_on && lookup_addr[`RT_ADDR_W-1:14] == 22'h20
        |-> lookup_type == s_r.fixed[1][7:0])
        else $error("First 16K sub-range did not use its byte.");

    a_fixed_last: assert property (@(posedge clk) disable iff (!resetn)
        s_r.enable && s_r.fixed_ranges_on && lookup_addr[`RT_ADDR_W-1:12] == 24'hFF
        |-> lookup_type == s_r.fixed[10][63:56])
        else $error("Last 4K sub-range did not use its top byte.");
endmodule

`default_nettype wire

// ===== dv/range_type_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "range_type_map.svh"

module range_type_unit_tb;
    import range_type_pkg::*;

    // ======================================================
    // Stimulus and observed signals.
    logic clk;
    logic resetn;
    logic cfg_rd;
    logic cfg_wr;
    logic [7:0] cfg_index;
    logic [63:0] cfg_wdata;
    logic [35:0] lookup_addr;
    logic [63:0] cfg_rdata;
    logic cfg_rd_valid;
    logic protection_fault;
    mem_type_t lookup_type;
    int failures;
    int check_count;

    range_type_unit uut (
        .clk(clk),
        .resetn(resetn),
        .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr),
        .cfg_index(cfg_index),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .cfg_rd_valid(cfg_rd_valid),
        .protection_fault(protection_fault),
        .lookup_addr(lookup_addr),
        .lookup_type(lookup_type)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ======================================================
    // Shared helpers.
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task results;
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Requests are held for exactly one taking edge, so the answer is read just after it.
    task access(input logic wr, input logic [7:0] idx, input logic [63:0] data);
        @(posedge clk);
        #1;
        cfg_wr = wr;
        cfg_rd = ~wr;
        cfg_index = idx;
        cfg_wdata = data;
        @(posedge clk);
        #1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
    endtask

    task wr(input logic [7:0] idx, input logic [63:0] data, input logic flt);
        access(1'b1, idx, data);
        check("fault", 64'(protection_fault), 64'(flt));
    endtask

    task rd(input logic [7:0] idx, input logic [63:0] exp);
        access(1'b0, idx, 64'h0);
        check("rd_valid", 64'(cfg_rd_valid), 64'h1);
        check("rdata", cfg_rdata, exp);
    endtask

    task look(input logic [35:0] addr, input logic [7:0] exp);
        @(posedge clk);
        #1;
        lookup_addr = addr;
        #2;
        check("type", 64'(lookup_type), 64'(exp));
    endtask

    function automatic logic [7:0] tsel(input int i);
        case (i % 5)
            0: tsel = 8'h00;
            1: tsel = 8'h01;
            2: tsel = 8'h04;
            3: tsel = 8'h05;
            default: tsel = 8'h06;
        endcase
    endfunction

    // ======================================================
    // Scenarios.
    task t_default;
        logic [7:0] bad [4];
        int bits [4];
        bad = '{8'h02, 8'h03, 8'h07, 8'hFF};
        bits = '{8, 9, 12, 63};
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, 64'hC00 | 64'(tsel(i + 5 * (i / 5))), 1'b0);
            look(36'hF_0000_0000, tsel(i));
            rd(8'h00, 64'hC00 | 64'(tsel(i)));
        end
        foreach (bad[i]) wr(8'h00, 64'hC00 | 64'(bad[i]), 1'b1);
        foreach (bits[i]) wr(8'h00, 64'hC06 | (64'h1 << bits[i]), 1'b1);
        rd(8'h00, 64'hC06);
        wr(8'h00, 64'h406, 1'b0);
        look(36'hF_0000_0000, 8'h00);
    endtask

    task t_fixed;
        logic [63:0] d;
        logic [35:0] a;
        logic [35:0] s;
        for (int r = 0; r < 11; r++) begin
            for (int k = 0; k < 8; k++) d[k*8+:8] = tsel(r * 9 + k);
            wr(8'(r + 1), d, 1'b0);
            rd(8'(r + 1), d);
        end
        look(36'h1_0000, 8'h00);
        wr(8'h00, 64'hC06, 1'b0);
        for (int r = 0; r < 11; r++) begin
            for (int k = 0; k < 8; k++) begin
                if (r == 0) begin
                    s = 36'h1_0000;
                    a = 36'(k) * s;
                end else if (r < 3) begin
                    s = 36'h4000;
                    a = 36'h8_0000 + 36'(r - 1) * 36'h2_0000 + 36'(k) * s;
                end else begin
                    s = 36'h1000;
                    a = 36'hC_0000 + 36'(r - 3) * 36'h8000 + 36'(k) * s;
                end
                look(a + s - 36'h1, tsel(r * 9 + k));
            end
        end
        look(36'h10_0000, 8'h06);
        wr(8'h01, 64'h02, 1'b1);
        look(36'h0, 8'h00);
    endtask

    task t_var;
        wr(8'h00, 64'hC01, 1'b0);
        wr(8'h10, 64'h20_0006, 1'b0);
        wr(8'h11, 64'hF_FFE0_0800, 1'b0);
        look(36'h2F_FFFF, 8'h06);
        look(36'h40_0000, 8'h01);
        look(36'h1F_FFFF, 8'h01);
        wr(8'h12, 64'h30_0000, 1'b0);
        wr(8'h13, 64'hF_FFFF_F000, 1'b0);
        look(36'h30_0000, 8'h06);
        wr(8'h13, 64'hF_FFFF_F800, 1'b0);
        look(36'h30_0FFF, 8'h00);
        look(36'h30_1000, 8'h06);
        wr(8'h14, 64'h28_0004, 1'b0);
        wr(8'h15, 64'hF_FFFF_F800, 1'b0);
        look(36'h28_0000, 8'h04);
        wr(8'h16, 64'h05, 1'b0);
        wr(8'h17, 64'hF_FFF0_0800, 1'b0);
        look(36'h1_0000, 8'h01);
        wr(8'h00, 64'h801, 1'b0);
        look(36'h1_0000, 8'h05);
        wr(8'h18, 64'h100_0004, 1'b0);
        wr(8'h19, 64'hF_FFEF_F800, 1'b0);
        look(36'h110_0800, 8'h04);
        look(36'h100_8000, 8'h01);
        wr(8'h1A, 64'h100, 1'b1);
        wr(8'h1A, 64'h10_0000_0000, 1'b1);
        wr(8'h1A, 64'h03, 1'b1);
        wr(8'h1B, 64'h1, 1'b1);
        rd(8'h1B, 64'h0);
        access(1'b0, 8'h20, 64'h0);
        check("fault", 64'(protection_fault), 64'h1);
        check("rd_valid", 64'(cfg_rd_valid), 64'h0);
        // A write and a read in one cycle: the write is taken, the read dropped.
        @(posedge clk);
        #1;
        cfg_wr = 1'b1;
        cfg_rd = 1'b1;
        cfg_index = 8'h00;
        cfg_wdata = 64'hC05;
        @(posedge clk);
        #1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        check("rd_valid", 64'(cfg_rd_valid), 64'h0);
        look(36'h40_0000, 8'h05);
        wr(8'h00, 64'h001, 1'b0);
        look(36'h2F_FFFF, 8'h00);
    endtask

    // A second reset in mid-run must drop the enable and the valid flag of pair 0.
    task t_reset;
        wr(8'h00, 64'hC06, 1'b0);
        resetn = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        rd(8'h00, 64'h0);
        rd(8'h11, 64'h0);
        look(36'h2F_FFFF, 8'h00);
    endtask

    // ======================================================
    // Main sequence and watchdog.
    initial begin
        failures = 0;
        check_count = 0;
        resetn = 1'b0;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_index = 8'h00;
        cfg_wdata = 64'h0;
        lookup_addr = 36'h0;
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_default();
        t_fixed();
        t_var();
        t_reset();
        results();
    end

    // The whole run takes well under 2000 cycles, so 20000 cycles means a hang.
    initial begin
        #400000;
        failures++;
        results();
    end
endmodule

`default_nettype wire
